// ===== src/conv_port.sv
// Conversion control and tri-state result port of a 16-bit sampling converter.
// Assumes select pins come from off-chip and are synchronised here;
// the sampled analog value arrives as a signed word on sample_word.
`timescale 1ns/1ps
module conv_port
  import conv_port_pkg::*;
#(
  parameter int CONV_CYC  = conv_port_pkg::CONV_CYCLES,
  parameter int LEAD_CYC  = conv_port_pkg::VALID_LEAD_CYC
) (
  input  wire logic                 core_clk,
  input  wire logic                 arst_n,
  input  wire logic                 clk_en,
  input  wire logic                 chip_sel_n,
  input  wire logic                 read_conv,
  input  wire logic signed [15:0]   sample_word,
  output logic                      busy_n,
  output logic                      hold,
  output logic [15:0]               result_bits_out,
  output logic [15:0]               result_bits_oe_n
);
  import conv_port_pkg::*;

  // Three-stage synchronisers for the pin inputs
  logic [2:0] cs_sync;
  logic [2:0] rc_sync;
  logic [2:0] next_cs_sync;
  logic [2:0] next_rc_sync;
  logic       cs_n_q;
  logic       rc_q;
  logic       next_cs_n_q;
  logic       next_rc_q;

  always_comb begin
    next_cs_sync = {cs_sync[1:0], chip_sel_n};
    next_rc_sync = {rc_sync[1:0], read_conv};
    // Change accepted only when stages two and three agree
    next_cs_n_q  = (cs_sync[1] == cs_sync[2]) ? cs_sync[2] : cs_n_q;
    next_rc_q    = (rc_sync[1] == rc_sync[2]) ? rc_sync[2] : rc_q;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cs_sync <= 3'h7;
      rc_sync <= 3'h7;
      cs_n_q  <= 1'b1;
      rc_q    <= 1'b1;
    end else if (clk_en) begin
      cs_sync <= next_cs_sync;
      rc_sync <= next_rc_sync;
      cs_n_q  <= next_cs_n_q;
      rc_q    <= next_rc_q;
    end
  end

  // Start request: both low now, not both low before; covers either order
  logic both_low;
  logic both_low_d;
  logic start_req;
  assign both_low  = !cs_n_q && !rc_q;
  assign start_req = both_low && !both_low_d;

  // Converter state, cycle counter and result capture
  conv_state_t state;
  conv_state_t next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic             next_busy_n;
  logic             next_hold;
  logic             next_both_low_d;
  logic             store_wr;
  logic [15:0]      stored;

  function automatic logic [CNT_W-1:0] cyc(input int n);
    cyc = CNT_W'(n);
  endfunction

  always_comb begin
    next_state      = state;
    next_cnt        = cnt;
    next_busy_n     = busy_n;
    next_hold       = hold;
    store_wr        = 1'b0;
    next_both_low_d = both_low;
    case (state)
      ST_TRACK: begin
        if (start_req) begin
          next_state  = ST_CONVERT;
          next_hold   = 1'b1;
          next_busy_n = 1'b0;
          next_cnt    = '0;
        end
      end
      ST_CONVERT: begin
        // Requests in here are ignored; edge memory keeps tracking
        next_cnt = cnt + cyc(1);
        if (cnt == cyc(CONV_CYC - LEAD_CYC - 1)) begin
          store_wr   = 1'b1;
          next_state = ST_PRESENT;
          next_cnt   = '0;
        end
      end
      ST_PRESENT: begin
        // Data already valid; busy waits the lead time
        next_cnt = cnt + cyc(1);
        if (cnt == cyc(LEAD_CYC - 1)) begin
          next_busy_n = 1'b1;
          next_hold   = 1'b0;
          next_state  = ST_TRACK;
          // Selects still low after busy rises restart: leave both_low_d low
          next_both_low_d = 1'b0;
        end
      end
      default: begin
        next_state  = ST_TRACK;
        next_busy_n = 1'b1;
        next_hold   = 1'b0;
      end
    endcase
  end

  // A restart is armed when busy rises; it fires only if selects stay low
  // for the restart window, checked by a small counter
  logic [CNT_W-1:0] rst_win;
  logic [CNT_W-1:0] next_rst_win;
  logic             armed;
  logic             next_armed;
  logic             start_eff;

  always_comb begin
    next_rst_win = rst_win;
    next_armed   = armed;
    if (state == ST_PRESENT && next_state == ST_TRACK) begin
      next_armed   = 1'b1;
      next_rst_win = '0;
    end else if (armed) begin
      if (!both_low) begin
        next_armed = 1'b0;
      end else begin
        next_rst_win = rst_win + cyc(1);
      end
    end
  end

  // Suppress the immediate restart until the window expires
  assign start_eff = armed && (rst_win < cyc(RESTART_CYC));

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state      <= ST_TRACK;
      cnt        <= '0;
      busy_n     <= 1'b1;
      hold       <= 1'b0;
      both_low_d <= 1'b0;
      rst_win    <= '0;
      armed      <= 1'b0;
    end else if (clk_en) begin
      state      <= (state == ST_TRACK && start_eff) ? ST_TRACK : next_state;
      cnt        <= next_cnt;
      busy_n     <= (state == ST_TRACK && start_eff) ? 1'b1 : next_busy_n;
      hold       <= (state == ST_TRACK && start_eff) ? 1'b0 : next_hold;
      both_low_d <= (state == ST_TRACK && start_eff) ? 1'b0 : next_both_low_d;
      rst_win    <= next_rst_win;
      armed      <= next_armed;
    end
  end

  // Result held until the next conversion; read any time later
  result_store #(.WIDTH(RESULT_W)) u_store (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .clk_en   (clk_en),
    .wr_en    (store_wr && clk_en),
    .wr_data  (sample_word),
    .rd_data  (stored)
  );

  // Output enable: only while read select and chip select allow and not mid-conversion
  logic        drive;
  logic        next_drive;
  logic [15:0] next_out;
  always_comb begin
    next_drive = rc_q && !cs_n_q && (next_state != ST_CONVERT);
    next_out   = (next_state == ST_PRESENT) ? sample_word : stored;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      drive            <= 1'b0;
      result_bits_out  <= RESULT_RESET;
      result_bits_oe_n <= 16'hffff;
    end else if (clk_en) begin
      drive            <= next_drive;
      result_bits_out  <= store_wr ? sample_word : next_out;
      result_bits_oe_n <= {16{~next_drive}};
    end
  end

  // Checks
  sequence s_conv_run;
    !busy_n [*8];
  endsequence

  a_busy_on_start: assert property (@(posedge core_clk) disable iff (!arst_n)
    clk_en && state == ST_TRACK && start_req && !start_eff |=> !busy_n && hold)
    else $error("busy did not fall at start");

  a_tristate_conv: assert property (@(posedge core_clk) disable iff (!arst_n)
    state == ST_CONVERT |-> result_bits_oe_n == 16'hffff)
    else $error("outputs driven during conversion");

  a_busy_lead: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(busy_n) |-> $past(state) == ST_PRESENT)
    else $error("busy rose without lead time");

  a_track_after: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(busy_n) |-> !hold)
    else $error("sample stage not back in track");

  a_ignore_req: assert property (@(posedge core_clk) disable iff (!arst_n)
    state == ST_CONVERT && clk_en && cnt == 8'h00 |=> s_conv_run)
    else $error("conversion cut short");

  a_oe_rule: assert property (@(posedge core_clk) disable iff (!arst_n)
    result_bits_oe_n[0] == 1'b0 |-> $past(rc_q) && !$past(cs_n_q))
    else $error("outputs enabled without read select");

  a_idle_busy: assert property (@(posedge core_clk) disable iff (!arst_n)
    state == ST_TRACK |-> busy_n)
    else $error("busy low while idle");

  a_result_code: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(busy_n) |-> stored == $past(stored))
    else $error("result changed at busy rise");

  // Length of each busy-low stretch, counted only on enabled cycles
  logic [CNT_W-1:0] busy_low_len;
  logic [CNT_W-1:0] next_busy_low_len;

  always_comb begin
    next_busy_low_len = busy_n ? '0 : busy_low_len + cyc(1);
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_low_len <= '0;
    end else if (clk_en) begin
      busy_low_len <= next_busy_low_len;
    end
  end

  // Start of a conversion as the pins see it
  sequence s_conv_begin;
    $fell(busy_n);
  endsequence

  // Restart window still open: armed since busy rose, count still below RESTART_CYC
  sequence s_window_open;
    clk_en && armed && state == ST_TRACK && rst_win < cyc(RESTART_CYC);
  endsequence

  // Restart window run out with both selects still low
  sequence s_window_shut;
    clk_en && armed && both_low && state == ST_TRACK && rst_win == cyc(RESTART_CYC);
  endsequence

  // Busy low exactly as long as one conversion
  a_conv_length: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(busy_n) |-> busy_low_len == cyc(CONV_CYC))
    else $error("busy low stretch has wrong length");

  // Hold taken and outputs released as busy falls
  a_conv_begin: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_conv_begin |-> hold && result_bits_oe_n == 16'hffff && state == ST_CONVERT)
    else $error("conversion start incomplete");

  // New word already on the outputs the cycle before busy rises
  a_data_lead: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(busy_n) |-> $past(result_bits_out) == stored)
    else $error("data not valid ahead of busy");

  // No restart while the window is open
  a_no_early_restart: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_window_open |=> busy_n)
    else $error("restart before window ran out");

  // Selects left low past the window start a fresh conversion
  a_late_restart: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_window_shut |=> !busy_n)
    else $error("no restart after window");

  // Idle read select with chip select low drives the outputs
  a_oe_on_read: assert property (@(posedge core_clk) disable iff (!arst_n)
    clk_en && state == ST_TRACK && next_state == ST_TRACK && rc_q && !cs_n_q
    |=> result_bits_oe_n == 16'h0000)
    else $error("outputs not enabled for read");

  // Stored word only changes at the end of a conversion
  a_result_kept: assert property (@(posedge core_clk) disable iff (!arst_n)
    state != ST_CONVERT |=> $stable(stored))
    else $error("stored result changed outside conversion");

  // Clock enable low freezes the pins
  a_freeze_state: assert property (@(posedge core_clk) disable iff (!arst_n)
    !clk_en |=> $stable(busy_n) && $stable(hold) && $stable(result_bits_oe_n))
    else $error("state moved while clock enable low");
endmodule // conv_port

// ===== src/conv_port_pkg.sv
// Constants for the parallel conversion port of a 16-bit sampling converter.
// Assumes a single 40 MHz core clock; the analog side is modelled digitally.
// What this block does
// - Chip select falling with read/convert low holds the sample and starts conversion.
// - During conversion result outputs stay high impedance and busy stays low.
// - Result is driven near the end, busy rises at least 25 ns later.
// - After conversion the sampling stage returns to track and acquires input.
// - When idle or finishing, outputs enabled while read/convert high and select low.
// - Both selects low 250 ns after busy rises start a new conversion.
// - Select low then read/convert low also starts a conversion.
// - Select raised early keeps outputs off at completion; result read later.
// - Read/convert left low and select raised keeps result for a later read.
// - Results are 16-bit two's complement, 7fff top, 8000 bottom.
// - A convert request during a running conversion is ignored.
// - Outputs are high impedance when select high, read/convert low, or converting.
package conv_port_pkg;
  localparam int  CLK_MHZ         = 40;
  localparam int  CLK_PERIOD_PS   = 1000000 / CLK_MHZ;
  localparam int  CONV_TIME_NS    = 3300;
  localparam int  CONV_CYCLES     = (CONV_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int  VALID_LEAD_NS   = 25;
  localparam int  VALID_LEAD_CYC  = (VALID_LEAD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int  RESTART_NS      = 250;
  localparam int  RESTART_CYC     = (RESTART_NS * 1000) / CLK_PERIOD_PS;
  localparam int  RESULT_W        = 16;
  localparam int  CNT_W           = 8;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [15:0] POS_FULL     = 16'h7fff;
  localparam logic [15:0] NEG_FULL     = 16'h8000;

  typedef enum logic [1:0] {
    ST_TRACK   = 2'b00,
    ST_CONVERT = 2'b01,
    ST_PRESENT = 2'b10
  } conv_state_t;
endpackage

// ===== src/result_store.sv
// Holds the latest conversion result in a register.
// Assumes writes come from the converter control on the same clock.
`timescale 1ns/1ps
module result_store #(
  parameter int WIDTH = 16
) (
  input  wire logic             core_clk,
  input  wire logic             arst_n,
  input  wire logic             clk_en,
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_data,
  output logic      [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] next_rd_data;

  // Keep old word unless a new one is written
  always_comb begin
    next_rd_data = wr_en ? wr_data : rd_data;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data <= '0;
    end else if (clk_en) begin
      rd_data <= next_rd_data;
    end
  end
endmodule // result_store

// ===== testbench/host_latch.sv
// Host-side capture latch: resolves the result bus and latches it as busy rises.
// Assumes the design's enable-low outputs; no pull on the bus lines.
`timescale 1ns/1ps
module host_latch (
  input  wire logic        core_clk,
  input  wire logic        busy_n,
  input  wire logic [15:0] result_bits_out,
  input  wire logic [15:0] result_bits_oe_n,
  output logic      [15:0] pins,
  output logic      [15:0] latched
);
  logic [15:0] last = 16'h0000;

  // Released bits show a toggling pattern, never a stale value
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      pins[i] = result_bits_oe_n[i] ? ~last[i] : result_bits_out[i];
    end
  end

  always @(posedge core_clk) last <= pins;

  // Capture on the rising edge of busy, as external latches would
  always @(posedge busy_n) latched <= pins;
endmodule // host_latch

// ===== testbench/tb_top.sv
// Self-checking bench for the conversion port with a host capture latch.
// Assumes a 40 MHz clock and a shortened conversion count.
`timescale 1ns/1ps
module tb_top;
  import conv_port_pkg::*;
  localparam int CONV = 20;
  logic               core_clk;
  logic               arst_n;
  logic               clk_en;
  logic               chip_sel_n;
  logic               read_conv;
  logic signed [15:0] sample_word;
  logic               busy_n;
  logic               hold;
  logic [15:0]        result_bits_out;
  logic [15:0]        result_bits_oe_n;
  logic [15:0]        pins;
  logic [15:0]        latched;
  int                 errors;
  int                 compares;
  int                 cyc = 0;
  int                 t0;

  conv_port #(.CONV_CYC(CONV), .LEAD_CYC(1)) conv_port_i (
    .core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en), .chip_sel_n(chip_sel_n),
    .read_conv(read_conv), .sample_word(sample_word), .busy_n(busy_n), .hold(hold),
    .result_bits_out(result_bits_out), .result_bits_oe_n(result_bits_oe_n));
  host_latch host_latch_i (.core_clk(core_clk), .busy_n(busy_n), .pins(pins),
    .result_bits_out(result_bits_out), .result_bits_oe_n(result_bits_oe_n), .latched(latched));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) cyc <= cyc + 1;

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Inputs change 1 ns after the edge, outputs are read there too
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wait_busy(input logic lvl, input int max);
    int n;
    n = 0;
    while (busy_n !== lvl && n < max) begin
      step(1);
      n++;
    end
    chk("busy level", {15'h0, lvl}, {15'h0, busy_n});
  endtask
  // Selects stay still for a few cycles before the start edge
  task automatic start(input logic rc_first);
    if (rc_first) read_conv = 1'b0;
    else chip_sel_n = 1'b0;
    step(4);
    read_conv = 1'b0;
    chip_sel_n = 1'b0;
    wait_busy(1'b0, 8);
    t0 = cyc;
    chk("hold", 16'h1, {15'h0, hold});
    chk("oe start", 16'hffff, result_bits_oe_n);
  endtask
  task automatic finish_conv();
    chk("oe mid", 16'hffff, result_bits_oe_n);
    wait_busy(1'b1, CONV + 4);
    chk("busy low cycles", 16'(CONV), 16'(cyc - t0));
  endtask
  // Idle gap keeps request spacing above 160 cycles
  task automatic gap();
    chip_sel_n = 1'b1;
    read_conv = 1'b1;
    step(140);
    chk("busy idle", 16'h1, {15'h0, busy_n});
    chk("oe idle", 16'hffff, result_bits_oe_n);
    chk("track", 16'h0, {15'h0, hold});
  endtask

  task automatic t_read(input logic [15:0] s, input logic rc_first);
    sample_word = s;
    start(rc_first);
    step(2);
    read_conv = 1'b1;
    finish_conv();
    chk("latched", s, latched);
    chk("pins", s, pins);
    chk("oe after", 16'h0000, result_bits_oe_n);
    gap();
    $display("test read %h done", s);
  endtask
  task automatic t_late(input logic keep_rc_low);
    sample_word = 16'h1234;
    start(1'b1);
    step(2);
    chip_sel_n = 1'b1;
    if (!keep_rc_low) read_conv = 1'b1;
    finish_conv();
    step(2);
    chk("oe held off", 16'hffff, result_bits_oe_n);
    read_conv = 1'b1;
    step(1);
    chip_sel_n = 1'b0;
    step(6);
    chk("late read", 16'h1234, pins);
    gap();
    $display("test late read %0d done", keep_rc_low);
  endtask
  task automatic t_ignore();
    sample_word = 16'h0f0f;
    start(1'b1);
    step(2);
    chip_sel_n = 1'b1;
    step(3);
    chip_sel_n = 1'b0;
    step(3);
    read_conv = 1'b1;
    finish_conv();
    chk("ignored request", 16'h0f0f, pins);
    gap();
    $display("test ignore done");
  endtask
  // Both selects left low past busy rising force a fresh conversion
  task automatic t_restart();
    sample_word = 16'h5555;
    start(1'b1);
    finish_conv();
    wait_busy(1'b0, 16);
    t0 = cyc;
    read_conv = 1'b1;
    chip_sel_n = 1'b1;
    finish_conv();
    gap();
    $display("test restart done");
  endtask

  // Clock enable low mid-conversion stretches busy by the frozen cycles
  task automatic t_freeze();
    sample_word = 16'h3c3c;
    start(1'b1);
    step(2);
    read_conv = 1'b1;
    step(2);
    clk_en = 1'b0;
    step(10);
    chk("frozen busy", 16'h0, {15'h0, busy_n});
    clk_en = 1'b1;
    wait_busy(1'b1, CONV + 8);
    chk("busy low frozen", 16'(CONV + 10), 16'(cyc - t0));
    chk("frozen result", 16'h3c3c, pins);
    gap();
    $display("test freeze done");
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    arst_n = 1'b0;
    clk_en = 1'b1;
    chip_sel_n = 1'b1;
    read_conv = 1'b1;
    sample_word = 16'sh0000;
    errors = 0;
    compares = 0;
    step(5);
    chk("busy reset", 16'h1, {15'h0, busy_n});
    chk("oe reset", 16'hffff, result_bits_oe_n);
    arst_n = 1'b1;
    step(4);
    t_read(16'h7fff, 1'b1);
    t_read(16'h0000, 1'b1);
    t_read(16'hffff, 1'b1);
    t_read(16'h8000, 1'b1);
    t_read(16'h2468, 1'b0);
    t_late(1'b0);
    t_late(1'b1);
    t_ignore();
    t_restart();
    t_freeze();
    report_and_stop();
  end
  // Tests need about 50 us; a hang is cut well after that
  initial begin
    #200us;
    errors++;
    report_and_stop();
  end
endmodule // tb_top
